// *** src/pesm_top.sv ***
// top of the printer engine sensor monitor
// assumes all inputs synchronous to core_clk; toner_sense high = magnets in encounter
`timescale 1ns/100ps
`default_nettype none
module pesm_top
	import pesm_pkg::*;
#(
	parameter int unsigned LOW_THRESH  = LOW_THRESH_CLKS,
	parameter int unsigned CYCLE_CLKS  = SENSE_CYCLE_CLKS
)
(
	input  wire logic            core_clk,
	input  wire logic            srst,
	input  wire logic            cover_switch_on,
	input  wire logic            toner_sense,
	input  wire logic            drum_motor_run,
	input  wire logic            stacker_full_sense,
	input  wire logic            page_start_req,
	input  wire logic            cassette_present,
	input  wire logic            size_tab_switch_first,
	input  wire logic            size_tab_switch_second,
	input  wire logic            size_tab_switch_third,
	input  wire logic            size_tab_switch_fourth,
	output logic                 cover_open_notify,
	output logic                 stacker_full,
	output logic                 page_start_grant,
	output pesm_toner_rpt_t      toner_rpt,
	output pesm_size_rpt_t       size_rpt
);

	////////////////////////////////////////////////////////////////////////
	// cover and stacker
	// raw full sense also blocks grants in the cycle before stacker_full rises

	always_ff @(posedge core_clk)
	begin
		if (srst)
			cover_open_notify <= 1'b0;
		else
			cover_open_notify <= ~cover_switch_on;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			stacker_full <= 1'b0;
		else
			stacker_full <= stacker_full_sense;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			page_start_grant <= 1'b0;
		else
			page_start_grant <= page_start_req && !stacker_full_sense && !stacker_full;
	end

	////////////////////////////////////////////////////////////////////////
	// toner encounter measurement

	logic             sense_d_r;
	logic [CNT_W-1:0] enc_cnt_r;
	logic             sample_ev;
	logic             sample_low;

	// a sample is one finished encounter: falling edge of toner_sense
	assign sample_ev  = drum_motor_run && sense_d_r && !toner_sense;
	assign sample_low = (enc_cnt_r >= CNT_W'(LOW_THRESH));

	always_ff @(posedge core_clk)
	begin
		if (srst)
			sense_d_r <= 1'b0;
		else if (drum_motor_run)
			sense_d_r <= toner_sense;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			enc_cnt_r <= '0;
		else if (!drum_motor_run)
			enc_cnt_r <= enc_cnt_r;
		else if (toner_sense && !sense_d_r)
			enc_cnt_r <= CNT_W'(1);
		// saturate: a stuck lever must read low, never wrap to full
		else if (toner_sense && enc_cnt_r != '1)
			enc_cnt_r <= enc_cnt_r + CNT_W'(1);
	end

	////////////////////////////////////////////////////////////////////////
	// toner low qualification

	logic [1:0] low_run_r;
	logic [1:0] full_run_r;
	logic       toner_low_r;
	logic       toner_alarm_r;
	logic       smp_pulse_r;
	logic       smp_low_r;

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			low_run_r  <= '0;
			full_run_r <= '0;
		end
		else if (sample_ev)
		begin
			if (sample_low)
			begin
				full_run_r <= '0;
				if (low_run_r != 2'(CONSEC_SAMPLES))
					low_run_r <= low_run_r + 2'h1;
			end
			else
			begin
				low_run_r <= '0;
				if (full_run_r != 2'(CONSEC_SAMPLES))
					full_run_r <= full_run_r + 2'h1;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			toner_low_r <= 1'b0;
		else if (sample_ev && sample_low && low_run_r == 2'(CONSEC_SAMPLES - 1))
			toner_low_r <= 1'b1;
		else if (sample_ev && !sample_low && full_run_r == 2'(CONSEC_SAMPLES - 1))
			toner_low_r <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			smp_pulse_r <= 1'b0;
			smp_low_r   <= 1'b0;
		end
		else
		begin
			smp_pulse_r <= sample_ev;
			if (sample_ev)
				smp_low_r <= sample_low;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// no-change alarm

	localparam int unsigned ALARM_CLKS = ALARM_CYCLES * CYCLE_CLKS;

	logic [CNT_W-1:0] idle_cnt_r;
	logic             sense_chg;

	assign sense_chg = (toner_sense != sense_d_r);

	always_ff @(posedge core_clk)
	begin
		if (srst)
			idle_cnt_r <= '0;
		else if (!drum_motor_run)
			idle_cnt_r <= idle_cnt_r;
		else if (sense_chg)
			idle_cnt_r <= '0;
		// stop at the limit so the alarm holds without wrapping
		else if (idle_cnt_r != CNT_W'(ALARM_CLKS))
			idle_cnt_r <= idle_cnt_r + CNT_W'(1);
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			toner_alarm_r <= 1'b0;
		else if (drum_motor_run && sense_chg)
			toner_alarm_r <= 1'b0;
		else if (drum_motor_run && idle_cnt_r == CNT_W'(ALARM_CLKS - 1))
			toner_alarm_r <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// report struct, one flop per field

	always_comb
	begin
		toner_rpt.toner_low    = toner_low_r;
		toner_rpt.toner_alarm  = toner_alarm_r;
		toner_rpt.sample_pulse = smp_pulse_r;
		toner_rpt.sample_low   = smp_low_r;
	end

	////////////////////////////////////////////////////////////////////////
	// cassette size

	logic cas_d_r;
	logic insert_pulse;

	always_ff @(posedge core_clk)
	begin
		if (srst)
			cas_d_r <= 1'b0;
		else
			cas_d_r <= cassette_present;
	end

	// cassette present out of reset counts as an insertion
	assign insert_pulse = cassette_present && !cas_d_r;

	pesm_size_decode u_size
	(
		.core_clk     (core_clk),
		.srst         (srst),
		.insert_pulse (insert_pulse),
		.sw_code      ({size_tab_switch_first, size_tab_switch_second,
		                size_tab_switch_third, size_tab_switch_fourth}),
		.rpt          (size_rpt)
	);

endmodule // pesm_top
`default_nettype wire

// *** src/pesm_pkg.sv ***
// constants and carrier types for the printer engine sensor monitor
// assumes one 20 MHz core clock; all sensor inputs already synchronous
//
// Function
// - cover switch off means cover open; notify main controller.
// - long magnet encounter interval marks a toner sample low, short marks full.
// - toner low established after two consecutive low samples.
// - toner low cancelled after two consecutive full samples.
// - alarm when toner sensor unchanged for two 2.727 s sensing cycles.
// - drum motor stopped: no sampling, no counting, no alarm timing.
// - stacker full sensor flags full and inhibits following pages.
// - decode four size switches into paper size on cassette insertion.
package pesm_pkg;

	localparam int unsigned CLK_HZ           = 20_000_000;
	localparam int unsigned SENSE_CYCLE_MS   = 2727;
	localparam int unsigned SENSE_CYCLE_CLKS = SENSE_CYCLE_MS * (CLK_HZ / 1000);
	localparam int unsigned ALARM_CYCLES     = 2;
	localparam int unsigned CONSEC_SAMPLES   = 2;
	// default encounter threshold, arbitrary: 0.5 s
	localparam int unsigned LOW_THRESH_CLKS  = CLK_HZ / 2;
	localparam int unsigned CNT_W            = 32;

	typedef enum logic [3:0]
	{
		PESM_SIZE_UNKNOWN,
		PESM_SIZE_LETTER,
		PESM_SIZE_EXECUTIVE,
		PESM_SIZE_A4,
		PESM_SIZE_LEGAL14,
		PESM_SIZE_LEGAL13,
		PESM_SIZE_B5,
		PESM_SIZE_A5,
		PESM_SIZE_A6
	} pesm_size_t;

	// switch codes, first switch in the msb
	localparam logic [3:0] SW_LETTER    = 4'h7;
	localparam logic [3:0] SW_EXECUTIVE = 4'h5;
	localparam logic [3:0] SW_A4        = 4'h3;
	localparam logic [3:0] SW_LEGAL14   = 4'he;
	localparam logic [3:0] SW_LEGAL13   = 4'hb;
	localparam logic [3:0] SW_B5        = 4'hd;
	localparam logic [3:0] SW_A5        = 4'hc;
	localparam logic [3:0] SW_A6        = 4'h9;

	typedef struct packed
	{
		pesm_size_t size;
		logic       valid;
		logic       unknown;
		logic       unsupported;
	} pesm_size_rpt_t;

	typedef struct packed
	{
		logic toner_low;
		logic toner_alarm;
		logic sample_pulse;
		logic sample_low;
	} pesm_toner_rpt_t;

endpackage

// *** src/pesm_size_decode.sv ***
// paper size decoder, registered
// assumes switch levels are stable while insert_pulse is high
`timescale 1ns/100ps
`default_nettype none
module pesm_size_decode
	import pesm_pkg::*;
(
	input  wire logic           core_clk,
	input  wire logic           srst,
	input  wire logic           insert_pulse,
	input  wire logic [3:0]     sw_code,
	output var  pesm_size_rpt_t rpt
);

	pesm_size_t size_nxt;

	always_comb
	begin
		case (sw_code)
			SW_LETTER:    size_nxt = PESM_SIZE_LETTER;
			SW_EXECUTIVE: size_nxt = PESM_SIZE_EXECUTIVE;
			SW_A4:        size_nxt = PESM_SIZE_A4;
			SW_LEGAL14:   size_nxt = PESM_SIZE_LEGAL14;
			SW_LEGAL13:   size_nxt = PESM_SIZE_LEGAL13;
			SW_B5:        size_nxt = PESM_SIZE_B5;
			SW_A5:        size_nxt = PESM_SIZE_A5;
			SW_A6:        size_nxt = PESM_SIZE_A6;
			default:      size_nxt = PESM_SIZE_UNKNOWN;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rpt <= '{PESM_SIZE_UNKNOWN, 1'b0, 1'b0, 1'b0};
		end
		else if (insert_pulse)
		begin
			rpt.size        <= size_nxt;
			rpt.valid       <= (size_nxt != PESM_SIZE_UNKNOWN) && (size_nxt != PESM_SIZE_A6);
			rpt.unknown     <= (size_nxt == PESM_SIZE_UNKNOWN);
			rpt.unsupported <= (size_nxt == PESM_SIZE_A6);
		end
	end

endmodule // pesm_size_decode
`default_nettype wire

// *** verif/pesm_assertions.sv ***
// checker on the pesm_top ports
// assumes one clock and sync active-high reset; bound at file end
`timescale 1ns/100ps
`default_nettype none
module pesm_checker
	import pesm_pkg::*;
(
	input wire logic            core_clk,
	input wire logic            srst,
	input wire logic            cover_switch_on,
	input wire logic            toner_sense,
	input wire logic            drum_motor_run,
	input wire logic            stacker_full_sense,
	input wire logic            cassette_present,
	input wire logic            cover_open_notify,
	input wire logic            stacker_full,
	input wire logic            page_start_grant,
	input wire pesm_toner_rpt_t toner_rpt,
	input wire pesm_size_rpt_t  size_rpt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	cover_notify_a: assert property (!$past(srst) |-> cover_open_notify == !$past(cover_switch_on))
		else $error("cover notify wrong");
	stack_flag_a: assert property (!$past(srst) |-> stacker_full == $past(stacker_full_sense))
		else $error("stacker flag wrong");
	page_block_a: assert property ($past(stacker_full_sense) |-> !page_start_grant)
		else $error("page granted while full");
	sample_edge_a: assert property (toner_rpt.sample_pulse |-> $past(drum_motor_run) && !$past(toner_sense))
		else $error("sample without falling sense");
	low_set_a: assert property ($rose(toner_rpt.toner_low) |-> toner_rpt.sample_pulse && toner_rpt.sample_low)
		else $error("toner low set without low sample");
	low_clear_a: assert property ($fell(toner_rpt.toner_low) |-> toner_rpt.sample_pulse && !toner_rpt.sample_low)
		else $error("toner low cleared without full sample");
	drum_freeze_a: assert property (!$past(drum_motor_run) |-> !toner_rpt.sample_pulse && $stable(toner_rpt.toner_low))
		else $error("toner monitor active with drum stopped");
	size_hold_a: assert property (!$past(srst) && !$rose(cassette_present)
		|=> $stable(size_rpt))
		else $error("size report changed without insertion");
endmodule // pesm_checker
bind pesm_top pesm_checker i_chk (.core_clk, .srst, .cover_switch_on, .toner_sense, .drum_motor_run,
	.stacker_full_sense, .cassette_present, .cover_open_notify, .stacker_full, .page_start_grant,
	.toner_rpt, .size_rpt);
`default_nettype wire

// *** verif/pesm_host_model.sv ***
// main controller model: requests pages, counts grants
// assumes grant one cycle after a held request
`timescale 1ns/100ps
`default_nettype none
module pesm_host_model
(
	input  wire logic      core_clk,
	input  wire logic      srst,
	input  wire logic      want_page,
	input  wire logic      page_start_grant,
	output var  logic      page_start_req,
	output var  logic [7:0] pages
);
	always_ff @(posedge core_clk)
	begin
		page_start_req <= !srst && want_page && !page_start_grant;
		pages <= srst ? 8'h00 : pages + {7'h00, page_start_grant};
	end
endmodule // pesm_host_model
`default_nettype wire

// *** verif/printer_engine_sensor_monitor_tb_top.sv ***
// testbench for pesm_top with the host model
// assumes short sim parameters: threshold 4, cycle 10 clocks
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module printer_engine_sensor_monitor_tb_top
	import pesm_pkg::*;
;
	localparam int unsigned CYC = 10;
	logic core_clk = 0, srst = 1, cov = 1, sense = 0, drum = 1, stk = 0, cas = 0, want = 0;
	logic [3:0] sw = 4'h0;
	logic req, full, grant, notify;
	logic [7:0] pages;
	pesm_toner_rpt_t trpt;
	pesm_size_rpt_t srpt, exp;
	int miscompares = 0, n_checks = 0;
	always #25 core_clk = ~core_clk;
	pesm_top #(.LOW_THRESH(4), .CYCLE_CLKS(CYC)) i_dut (.core_clk, .srst,
		.cover_switch_on(cov), .toner_sense(sense), .drum_motor_run(drum),
		.stacker_full_sense(stk), .page_start_req(req), .cassette_present(cas),
		.size_tab_switch_first(sw[3]), .size_tab_switch_second(sw[2]),
		.size_tab_switch_third(sw[1]), .size_tab_switch_fourth(sw[0]),
		.cover_open_notify(notify), .stacker_full(full), .page_start_grant(grant),
		.toner_rpt(trpt), .size_rpt(srpt));
	pesm_host_model i_host (.core_clk, .srst, .want_page(want), .page_start_grant(grant),
		.page_start_req(req), .pages);
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic cover_and_stack();
		cov <= 0; tick(2); `CHK(notify, 1'b1)
		cov <= 1; tick(2); `CHK(notify, 1'b0)
		stk <= 1; want <= 1; tick(12);
		`CHK(full, 1'b1)
		`CHK(pages, 8'h00)
		stk <= 0; tick(8); `CHK(pages != 8'h00, 1'b1)
		want <= 0; tick(3);
	endtask
	// one encounter of n clocks, then wait for its sample
	task automatic encounter(int n, logic low, logic tl);
		int i;
		sense <= 1; tick(n); sense <= 0;
		for (i = 0; i < 6 && trpt.sample_pulse !== 1'b1; i++) tick(1);
		if (i == 6)
		begin
			miscompares++;
			tally_and_finish();
		end
		`CHK(trpt.sample_low, low)
		`CHK(trpt.toner_low, tl)
		tick(2);
	endtask
	task automatic toner_levels();
		encounter(6, 1, 0); encounter(2, 0, 0); encounter(4, 1, 0); encounter(5, 1, 1);
		encounter(2, 0, 1); encounter(9, 1, 1); encounter(3, 0, 1); encounter(1, 0, 0);
	endtask
	task automatic alarm_and_drum();
		sense <= 1;
		tick(1);
		sense <= 0;
		tick(2 * CYC);
		`CHK(trpt.toner_alarm, 1'b0)
		tick(2);
		`CHK(trpt.toner_alarm, 1'b1)
		sense <= 1;
		tick(3);
		`CHK(trpt.toner_alarm, 1'b0)
		drum <= 0;
		tick(3 * CYC);
		`CHK(trpt.toner_alarm, 1'b0)
		repeat (2)
		begin
			sense <= 0;
			tick(8);
			sense <= 1;
			tick(8);
		end
		`CHK(trpt.toner_low, 1'b0)
		drum <= 1;
		sense <= 0;
		tick(3);
	endtask
	// reset in mid-run clears every report, then inputs act again
	task automatic reset_mid_run();
		cov <= 0;
		tick(2);
		srst <= 1;
		tick(3);
		exp = '{PESM_SIZE_UNKNOWN, 1'b0, 1'b0, 1'b0};
		`CHK(notify, 1'b0)
		`CHK(srpt, exp)
		`CHK(trpt, 4'h0)
		srst <= 0;
		tick(1);
		`CHK(notify, 1'b0)
		tick(1);
		`CHK(notify, 1'b1)
		cov <= 1;
		tick(2);
	endtask
	task automatic size_table();
		for (int c = 0; c < 16; c++)
		begin
			sw <= c[3:0]; cas <= 0; tick(2); cas <= 1; tick(3);
			exp = '{PESM_SIZE_UNKNOWN, 1'b1, 1'b0, 1'b0};
			case (c[3:0])
				SW_LETTER: exp.size = PESM_SIZE_LETTER;
				SW_EXECUTIVE: exp.size = PESM_SIZE_EXECUTIVE;
				SW_A4: exp.size = PESM_SIZE_A4;
				SW_LEGAL14: exp.size = PESM_SIZE_LEGAL14;
				SW_LEGAL13: exp.size = PESM_SIZE_LEGAL13;
				SW_B5: exp.size = PESM_SIZE_B5;
				SW_A5: exp.size = PESM_SIZE_A5;
				SW_A6: exp = '{PESM_SIZE_A6, 1'b0, 1'b0, 1'b1};
				default: exp = '{PESM_SIZE_UNKNOWN, 1'b0, 1'b1, 1'b0};
			endcase
			`CHK(srpt, exp)
		end
	endtask
	initial
	begin
		tick(20); srst <= 0; tick(2);
		cover_and_stack();
		toner_levels();
		alarm_and_drum();
		size_table();
		reset_mid_run();
		tally_and_finish();
	end
endmodule // printer_engine_sensor_monitor_tb_top
`default_nettype wire
